// [design/part_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "part_cfg.svh"
// Overview of operation
// R1 - Eight-bit counter increments once per prescaler output tick.
// R2 - Overflow reloads counter from auto-reload value; prescaler untouched.
// R3 - Seven-bit prescaler, tap select picks divide by two to the n.
// R4 - Input clock is CPU clock or external clock per select bit.
// R5 - Run enable low freezes prescaler and counter.
// R6 - Reset clears counter, prescaler, selects CPU clock; here the clock select is an input port that reset does not touch.
// R7 - Force reload with run enable loads counter, clears prescaler.
// R8 - Counter access write loads counter and clears prescaler.
// R9 - Counter readable and writable while counting.
// R10 - Prescaler has no software access.
// R11 - Four hidden compares loaded from duty registers at overflow.
// R12 - Output enable drives channel pin as push-pull output.
// R13 - Shared PWM period is counter clock over 256 minus reload.
// R14 - Overflow sets polarity level; reaching compare restores opposite.
// R15 - Software sets compare above reload for a toggling pin.
// R16 - PWM generation stops during halt.
// R17 - Overflow sets flag; interrupt when overflow enable set.
// R18 - External mode counts 256 minus reload events per overflow.
// R19 - Software clears run enable before halt with external clock.
// R20 - Selected capture edge copies counter, sets flag, maybe interrupts.
// R21 - Capture blocked until value read; read clears flag.
// R22 - Capture interrupt pending while flag and enable set.
// R23 - Reading control status clears overflow flag.
// R24 - Polarity 0 high at or below compare; change immediate.
// R25 - Force reload reads as zero.
// R26 - Counter access write beats same-cycle increment or reload.
module part_timer (
    input  wire logic                     core_clk_i,
    input  wire logic                     reset_n_i,
    input  wire logic                     ext_clock_select_i,
    input  wire logic [2:0]               prescale_tap_select_i,
    input  wire logic                     counter_run_enable_i,
    input  wire logic                     force_reload_i,
    input  wire logic                     overflow_irq_enable_i,
    input  wire logic                     status_read_i,
    input  wire part_pkg::part_byte_type  auto_reload_reg_i,
    input  wire logic                     counter_write_i,
    input  wire part_pkg::part_byte_type  counter_wdata_i,
    input  wire part_pkg::part_byte_type  duty_cycle_reg0_i,
    input  wire part_pkg::part_byte_type  duty_cycle_reg1_i,
    input  wire part_pkg::part_byte_type  duty_cycle_reg2_i,
    input  wire part_pkg::part_byte_type  duty_cycle_reg3_i,
    input  wire logic [3:0]               channel_output_enable_i,
    input  wire logic [3:0]               channel_polarity_i,
    input  wire logic                     halt_mode_i,
    input  wire logic                     external_event_clock_i,
    input  wire logic [1:0]               capture_input_pin_i,
    input  wire logic [1:0]               capture_edge_select_i,
    input  wire logic [1:0]               capture_irq_enable_i,
    input  wire logic [1:0]               capture_read_i,
    output logic                          force_reload_rd_o,
    output part_pkg::part_byte_type       counter_access_reg_o,
    output logic                          overflow_flag_o,
    output logic                          overflow_irq_o,
    output logic [1:0]                    capture_flag_o,
    output logic [1:0]                    capture_irq_o,
    output part_pkg::part_byte_type       capture_value_reg0_o,
    output part_pkg::part_byte_type       capture_value_reg1_o,
    output logic [3:0]                    pwm_output_pin_o,
    output logic [3:0]                    pwm_output_oe_o
);
    import part_pkg::*;

    // ==========================================
    // Pin synchronisers and edge detection
    logic       ext_s1_q;
    logic       ext_s2_q;
    logic       ext_s3_q;
    logic [1:0] cap_s1_q;
    logic [1:0] cap_s2_q;
    logic [1:0] cap_s3_q;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            cap_s1_q <= 2'h0;
            cap_s2_q <= 2'h0;
            cap_s3_q <= 2'h0;
        end else begin
            ext_s1_q <= external_event_clock_i;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            cap_s1_q <= capture_input_pin_i;
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
        end
    end

    logic ext_rise;
    assign ext_rise = ext_s2_q & ~ext_s3_q;

    // ==========================================
    // Prescaler and counter
    logic [6:0]    pre_q;
    logic [6:0]    pre_d;
    part_byte_type cnt_q;
    part_byte_type cnt_d;
    logic          ovf_q;
    logic          ovf_d;
    logic          ovf_evt_q;
    logic          ovf_evt_d;
    logic          in_tick;
    logic          cnt_tick;
    logic [7:0]    pre_next;
    logic          wrap;

    // External clock is one tick per synchronised rising edge
    assign in_tick = ext_clock_select_i ? ext_rise : 1'b1; // [R4]

    always_comb begin
        pre_d     = pre_q;
        cnt_d     = cnt_q;
        ovf_evt_d = 1'b0;
        cnt_tick  = 1'b0;
        pre_next  = {1'b0, pre_q} + 8'h01;
        // Tick when all bits below the tap wrap to zero: divide by 2^n
        wrap      = 1'b1;
        for (int i = 0; i < `PART_PRE_W; i++) begin
            if (i < int'(prescale_tap_select_i) && pre_next[i] != 1'b0) begin
                wrap = 1'b0;
            end
        end
        if (counter_run_enable_i && in_tick) begin // [R5]
            pre_d    = pre_next[6:0]; // [R3]
            cnt_tick = wrap;
        end
        if (cnt_tick) begin
            if (cnt_q == `PART_CNT_MAX) begin
                cnt_d     = auto_reload_reg_i; // [R2] [R13] [R18]
                ovf_evt_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 8'h01; // [R1]
            end
        end
        if (force_reload_i && counter_run_enable_i) begin
            cnt_d = auto_reload_reg_i; // [R7]
            pre_d = `PART_ZERO7;
        end
        if (counter_write_i) begin
            cnt_d     = counter_wdata_i; // [R8] [R26]
            pre_d     = `PART_ZERO7;
            ovf_evt_d = 1'b0;
        end
        // Set wins over a same-cycle status read clear
        ovf_d = ovf_q;
        if (status_read_i) begin
            ovf_d = 1'b0; // [R23]
        end
        if (ovf_evt_d) begin
            ovf_d = 1'b1; // [R17]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            pre_q     <= `PART_ZERO7; // [R6]
            cnt_q     <= `PART_ZERO8;
            ovf_q     <= 1'b0;
            ovf_evt_q <= 1'b0;
        end else begin
            pre_q     <= pre_d;
            cnt_q     <= cnt_d;
            ovf_q     <= ovf_d;
            ovf_evt_q <= ovf_evt_d;
        end
    end

    // ==========================================
    // Input capture
    part_byte_type cap_q [2];
    part_byte_type cap_d [2];
    logic [1:0]    cf_q;
    logic [1:0]    cf_d;

    always_comb begin
        for (int c = 0; c < `PART_NUM_CAP; c++) begin
            cap_d[c] = cap_q[c];
            cf_d[c]  = cf_q[c];
            if (capture_read_i[c]) begin
                cf_d[c] = 1'b0; // [R21]
            end
            // Capture lost if it coincides with the read; the old value was read
            if (!cf_q[c] &&
                ((capture_edge_select_i[c] == PART_EDGE_RISE)
                    ? (cap_s2_q[c] & ~cap_s3_q[c])
                    : (~cap_s2_q[c] & cap_s3_q[c]))) begin
                cap_d[c] = cnt_q; // [R20]
                cf_d[c]  = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cap_q[0] <= `PART_ZERO8;
            cap_q[1] <= `PART_ZERO8;
            cf_q     <= 2'h0;
        end else begin
            cap_q[0] <= cap_d[0];
            cap_q[1] <= cap_d[1];
            cf_q     <= cf_d;
        end
    end

    // ==========================================
    // PWM channels
    part_byte_type duty [4];
    assign duty[0] = duty_cycle_reg0_i;
    assign duty[1] = duty_cycle_reg1_i;
    assign duty[2] = duty_cycle_reg2_i;
    assign duty[3] = duty_cycle_reg3_i;

    for (genvar g = 0; g < `PART_NUM_PWM; g++) begin : g_pwm
        part_pwm_chan u_chan (
            .core_clk_i (core_clk_i),
            .reset_n_i  (reset_n_i),
            .duty_i     (duty[g]),
            .count_i    (cnt_q),
            .overflow_i (ovf_evt_d),
            .polarity_i (channel_polarity_i[g]),
            .enable_i   (channel_output_enable_i[g]),
            .halt_i     (halt_mode_i),
            .pwm_o      (pwm_output_pin_o[g]),
            .pwm_oe_o   (pwm_output_oe_o[g])
        );
    end

    // ==========================================
    // Registered outputs
    logic irq_ovf_q;
    logic [1:0] irq_cap_q;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            irq_ovf_q <= 1'b0;
            irq_cap_q <= 2'h0;
        end else begin
            irq_ovf_q <= ovf_d & overflow_irq_enable_i; // [R17]
            irq_cap_q <= cf_d & capture_irq_enable_i; // [R22]
        end
    end

    // Counter visible live; prescaler has no port at all
    assign counter_access_reg_o = cnt_q; // [R9] [R10]
    assign force_reload_rd_o    = 1'b0; // [R25]
    assign overflow_flag_o      = ovf_q;
    assign overflow_irq_o       = irq_ovf_q;
    assign capture_flag_o       = cf_q;
    assign capture_irq_o        = irq_cap_q;
    assign capture_value_reg0_o = cap_q[0];
    assign capture_value_reg1_o = cap_q[1];

    // ==========================================
    // Assertions
    AST_RESET_CLEAR: assert property (@(posedge core_clk_i) // [R6]
        !reset_n_i |=> cnt_q == `PART_ZERO8 && pre_q == `PART_ZERO7 && !ovf_q)
        else $error("reset did not clear the counter");
    AST_WRITE_WINS: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R26]
        counter_write_i |=> cnt_q == $past(counter_wdata_i) && pre_q == `PART_ZERO7)
        else $error("counter write not taken");
    AST_STOP_FREEZE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R5]
        !counter_run_enable_i && !counter_write_i |=> $stable(cnt_q) && $stable(pre_q))
        else $error("counter moved while stopped");
    AST_RELOAD: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R2]
        cnt_tick && cnt_q == `PART_CNT_MAX && !counter_write_i && !force_reload_i
        |=> cnt_q == $past(auto_reload_reg_i) && ovf_q)
        else $error("overflow reload wrong");
    AST_PRE_KEEP: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R2]
        cnt_tick && cnt_q == `PART_CNT_MAX && !counter_write_i && !force_reload_i
        |=> pre_q == $past(pre_q) + `PART_PRE_ONE)
        else $error("prescaler disturbed by reload");
    AST_INC: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R1]
        cnt_tick && cnt_q != `PART_CNT_MAX && !counter_write_i && !force_reload_i
        |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("counter did not increment");
    AST_FORCE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R7]
        force_reload_i && counter_run_enable_i && !counter_write_i
        |=> cnt_q == $past(auto_reload_reg_i) && pre_q == `PART_ZERO7)
        else $error("force reload failed");
    AST_DIV1: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R3]
        counter_run_enable_i && !ext_clock_select_i && prescale_tap_select_i == 3'h0
        |-> cnt_tick)
        else $error("divide by one missed a tick");
    AST_EXT_ONLY: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R4]
        ext_clock_select_i && !ext_rise |-> !cnt_tick)
        else $error("tick without external edge");
    AST_OVF_CLR: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R23]
        status_read_i && !ovf_evt_d |=> !ovf_q)
        else $error("overflow flag not cleared");
    AST_OVF_SRC: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R17]
        $rose(ovf_q) |-> $past(cnt_q) == `PART_CNT_MAX)
        else $error("overflow flag without wrap");
    AST_OVF_IRQ: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R17]
        ovf_q && overflow_irq_enable_i && !status_read_i |=> overflow_irq_o)
        else $error("overflow irq missing");
    AST_OVF_QUIET: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R17]
        !overflow_irq_enable_i |=> !overflow_irq_o)
        else $error("overflow irq while disabled");
    AST_CAP_TAKE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R20]
        !cf_q[0] && capture_edge_select_i[0] == PART_EDGE_RISE && cap_s2_q[0] && !cap_s3_q[0]
        |=> cf_q[0] && cap_q[0] == $past(cnt_q))
        else $error("rising capture missed");
    AST_CAP_FALL: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R20]
        !cf_q[1] && capture_edge_select_i[1] == PART_EDGE_FALL && !cap_s2_q[1] && cap_s3_q[1]
        |=> cf_q[1] && cap_q[1] == $past(cnt_q))
        else $error("falling capture missed");
    AST_CAP_CLR: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R21]
        cf_q[0] && capture_read_i[0] |=> !cf_q[0])
        else $error("capture read did not clear flag");
    AST_CAP_BLOCK: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R21]
        cf_q[0] |=> $stable(cap_q[0]))
        else $error("capture overwritten");
    AST_CAP_BLOCK1: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R21]
        cf_q[1] |=> $stable(cap_q[1]))
        else $error("second capture overwritten");
    AST_CAP_IRQ: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R22]
        cf_q[1] && capture_irq_enable_i[1] && !capture_read_i[1] |=> capture_irq_o[1])
        else $error("capture irq not pending");
    AST_CAP_IRQ0: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R22]
        cf_q[0] && capture_irq_enable_i[0] && !capture_read_i[0] |=> capture_irq_o[0])
        else $error("first capture irq not pending");
    AST_CAP_IRQ_OFF: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R22]
        !capture_irq_enable_i[0] |=> !capture_irq_o[0])
        else $error("capture irq while disabled");
    AST_OE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R12]
        reset_n_i |=> pwm_output_oe_o == $past(channel_output_enable_i))
        else $error("output enable not followed");
    AST_HALT_HOLD: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R16]
        halt_mode_i |=> $stable(pwm_output_pin_o))
        else $error("pwm moved during halt");
    AST_FR_ZERO: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // [R25]
        !force_reload_rd_o)
        else $error("force reload read nonzero");

    // ==========================================
    // Coverage
    COV_OVF: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) ovf_evt_q);
    COV_HALT: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) halt_mode_i && ovf_evt_q);
    COV_CAP: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) cf_q[0] && cf_q[1]);
    COV_EXT: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
        ext_clock_select_i && cnt_tick);
    COV_WR: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
        counter_write_i && cnt_tick);
endmodule
`default_nettype wire

// [shared/part_cfg.svh]
`ifndef PART_CFG_SVH
`define PART_CFG_SVH
`define PART_CNT_W      8
`define PART_PRE_W      7
`define PART_TAP_W      3
`define PART_NUM_PWM    4
`define PART_NUM_CAP    2
`define PART_CNT_MAX    8'hFF
`define PART_ZERO8      8'h00
`define PART_ZERO7      7'h00
`define PART_PRE_ONE    7'h01
`endif

// [shared/part_pkg.sv]
`default_nettype none
package part_pkg;
    typedef logic [7:0] part_byte_type;
    typedef enum logic {
        PART_EDGE_FALL,
        PART_EDGE_RISE
    } part_edge_type;
endpackage
`default_nettype wire

// [design/part_pwm_chan.sv]
`timescale 1ns/1ps
`default_nettype none
`include "part_cfg.svh"
// ==========================================
// One PWM channel: hidden compare plus output level
module part_pwm_chan (
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_n_i,
    input  wire part_pkg::part_byte_type duty_i,
    input  wire part_pkg::part_byte_type count_i,
    input  wire logic                  overflow_i,
    input  wire logic                  polarity_i,
    input  wire logic                  enable_i,
    input  wire logic                  halt_i,
    output logic                       pwm_o,
    output logic                       pwm_oe_o
);
    import part_pkg::*;

    part_byte_type cmp_q;
    part_byte_type cmp_d;
    logic          pwm_q;
    logic          pwm_d;
    logic          oe_q;
    logic          oe_d;

    always_comb begin
        cmp_d = cmp_q;
        if (overflow_i) begin
            cmp_d = duty_i; // [R11]
        end
        // Level follows count vs compare, so a polarity change shows at once
        if (halt_i) begin
            pwm_d = pwm_q; // [R16]
        end else begin
            pwm_d = (count_i <= cmp_q) ? ~polarity_i : polarity_i; // [R14] [R24]
        end
        oe_d = enable_i; // [R12]
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cmp_q <= `PART_ZERO8;
            pwm_q <= 1'b0;
            oe_q  <= 1'b0;
        end else begin
            cmp_q <= cmp_d;
            pwm_q <= pwm_d;
            oe_q  <= oe_d;
        end
    end

    assign pwm_o    = pwm_q;
    assign pwm_oe_o = oe_q;
endmodule
`default_nettype wire

// [tb/part_ext_src.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Event clock and capture pin sources
module part_ext_src (
    input  wire logic  core_clk_i,
    output logic       event_clk_o,
    output logic [1:0] cap_pin_o
);
    // Pins idle low; the event clock only moves inside a burst
    initial begin
        event_clk_o = 1'h0;
        cap_pin_o   = 2'h0;
    end
    // Pins are synchronised, so a width below one clock cycle may be lost
    task automatic pulse_events(input int n, input int w);
        repeat (n) begin
            @(negedge core_clk_i);
            event_clk_o = 1'h1;
            repeat (w) @(negedge core_clk_i);
            event_clk_o = 1'h0;
            repeat (w - 1) @(negedge core_clk_i);
        end
    endtask
    task automatic set_cap(input int ch, input logic lvl);
        @(negedge core_clk_i);
        cap_pin_o[ch] = lvl;
    endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       core_clk_i = 1'h0;
    logic       reset_n_i  = 1'h0;
    logic       xsel = 1'h0, run = 1'h0, frl = 1'h0, overflow_irq_enable = 1'h0, srd = 1'h0, cwr = 1'h0;
    logic       halt = 1'h0, frl_rd, ovf, oirq, ev;
    logic [2:0] tap  = 3'h0;
    logic [7:0] arr  = 8'h00, wdat = 8'h00, cnt, cv0, cv1, v;
    logic [7:0] duty [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic [3:0] oen = 4'h0, pol = 4'h0, pwm, oe, p;
    logic [1:0] csel = 2'h0, cie = 2'h0, crd = 2'h0, cf, cirq, cpin;
    int         n_fail = 0, n_checks = 0, n, len, hi, lo, chg;
    initial forever #25 core_clk_i = ~core_clk_i;
    part_ext_src src (.core_clk_i(core_clk_i), .event_clk_o(ev), .cap_pin_o(cpin));
    part_timer dut (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ext_clock_select_i(xsel),
        .prescale_tap_select_i(tap), .counter_run_enable_i(run), .force_reload_i(frl),
        .overflow_irq_enable_i(overflow_irq_enable), .status_read_i(srd), .auto_reload_reg_i(arr),
        .counter_write_i(cwr), .counter_wdata_i(wdat), .duty_cycle_reg0_i(duty[0]),
        .duty_cycle_reg1_i(duty[1]), .duty_cycle_reg2_i(duty[2]), .duty_cycle_reg3_i(duty[3]),
        .channel_output_enable_i(oen), .channel_polarity_i(pol), .halt_mode_i(halt),
        .external_event_clock_i(ev), .capture_input_pin_i(cpin), .capture_edge_select_i(csel),
        .capture_irq_enable_i(cie), .capture_read_i(crd), .force_reload_rd_o(frl_rd),
        .counter_access_reg_o(cnt), .overflow_flag_o(ovf), .overflow_irq_o(oirq),
        .capture_flag_o(cf), .capture_irq_o(cirq), .capture_value_reg0_o(cv0),
        .capture_value_reg1_o(cv1), .pwm_output_pin_o(pwm), .pwm_output_oe_o(oe));
    // ==========================================
    // Shared tasks
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tk(input int k);
        repeat (k) @(negedge core_clk_i);
    endtask
    task automatic expire(input string what);
        n_fail++;
        $display("[ERR] %s expected event seen timeout", what);
        complete_run();
    endtask
    task automatic cnt_write(input logic [7:0] d);
        cwr  = 1'h1;
        wdat = d;
        tk(1);
        cwr  = 1'h0;
    endtask
    task automatic wait_pin(input int ch, input logic lvl);
        for (int i = 0; pwm[ch] !== lvl; i++) begin
            if (i > 300) expire("pwm pin");
            tk(1);
        end
    endtask
    // Second step is timed so the phase left by the write does not matter
    task automatic step_len(output int s);
        v = cnt;
        for (int i = 0; cnt === v; i++) begin
            if (i > 300) expire("counter step");
            tk(1);
        end
        v = cnt;
        s = 0;
        while (cnt === v && s < 300) begin
            tk(1);
            s++;
        end
    endtask
    // ==========================================
    // Main sequence
    initial begin
        tk(3);
        reset_n_i = 1'h1;
        check("reset count", 8'h00, cnt);
        check("reset pins", 8'h00, {cf, ovf, oirq, oe});
        arr = 8'h40;
        overflow_irq_enable = 1'h1;
        run = 1'h1;
        cnt_write(8'hFE);
        check("written count", 8'hFE, cnt);
        tk(1);
        check("count up", 8'hFF, cnt);
        tk(1);
        check("reload", 8'h40, cnt);
        check("overflow flag", 8'h01, ovf);
        tk(1);
        check("overflow irq", 8'h01, oirq);
        srd = 1'h1;
        tk(1);
        srd = 1'h0;
        check("flag after read", 8'h00, ovf);
        for (n = 0; n < 8; n++) begin
            tap = n[2:0];
            cnt_write(8'h10);
            step_len(len);
            check("tap step", 8'(1 << n), 8'(len));
        end
        tap = 3'h0;
        run = 1'h0;
        v   = cnt;
        frl = 1'h1;
        check("force reload read", 8'h00, frl_rd);
        tk(20);
        frl = 1'h0;
        check("frozen count", v, cnt);
        tap = 3'h7;
        run = 1'h1;
        frl = 1'h1;
        tk(1);
        frl = 1'h0;
        check("forced reload", 8'h40, cnt);
        arr = 8'hF0;
        for (n = 0; n < 4; n++) duty[n] = 8'hF2 + 8'(3 * n);
        pol = 4'hA;
        oen = 4'hF;
        tap = 3'h0;
        tk(40);
        check("output enable", 8'h0F, oe);
        for (n = 0; n < 4; n++) begin
            wait_pin(n, 1'h0);
            wait_pin(n, 1'h1);
            for (hi = 0; pwm[n] === 1'h1 && hi < 100; hi++) tk(1);
            for (lo = 0; pwm[n] === 1'h0 && lo < 100; lo++) tk(1);
            check("high width", pol[n] ? 8'hFF - duty[n] : duty[n] - 8'hEF, 8'(hi));
            check("period", 8'h10, 8'(hi + lo));
        end
        halt = 1'h1;
        tk(2);
        p = pwm;
        chg = 0;
        repeat (40) begin
            tk(1);
            if (pwm !== p) chg++;
        end
        check("halt changes", 8'h00, 8'(chg));
        halt = 1'h0;
        run  = 1'h0;
        cnt_write(8'hF3);
        tk(2);
        check("low above compare", 8'h00, pwm[0]);
        duty[0] = 8'hFF;
        tk(3);
        check("compare buffered", 8'h00, pwm[0]);
        pol[0] = 1'h1;
        tk(2);
        check("polarity flip", 8'h01, pwm[0]);
        xsel = 1'h1;
        arr  = 8'hFD;
        run  = 1'h1;
        cnt_write(8'hFD);
        srd = 1'h1;
        tk(1);
        srd = 1'h0;
        src.pulse_events(2, 3);
        tk(4);
        check("event count", 8'hFF, cnt);
        check("no flag yet", 8'h00, ovf);
        src.pulse_events(1, 3);
        tk(4);
        check("event overflow", 8'h01, ovf);
        check("event reload", 8'hFD, cnt);
        run  = 1'h0;
        halt = 1'h1;
        src.pulse_events(2, 3);
        tk(4);
        check("halted events", 8'hFD, cnt);
        halt = 1'h0;
        xsel = 1'h0;
        csel = 2'h1;
        cie  = 2'h1;
        src.set_cap(1, 1'h1);
        tk(5);
        check("wrong edge", 8'h00, cf);
        src.set_cap(0, 1'h1);
        tk(5);
        check("capture flag", 8'h01, cf);
        check("capture value", 8'hFD, cv0);
        check("capture irq", 8'h01, cirq);
        cnt_write(8'h33);
        src.set_cap(0, 1'h0);
        tk(3);
        src.set_cap(0, 1'h1);
        tk(5);
        check("blocked value", 8'hFD, cv0);
        check("irq pending", 8'h01, cirq);
        crd = 2'h1;
        tk(1);
        crd = 2'h0;
        tk(2);
        check("flag cleared", 8'h00, {cf, cirq});
        src.set_cap(1, 1'h0);
        tk(5);
        check("falling capture", 8'h02, cf);
        check("falling value", 8'h33, cv1);
        check("irq disabled", 8'h00, cirq);
        complete_run();
    end
endmodule
`default_nettype wire
